//--- rtl/twbh_pkg.sv
// Constants, register map and state type for the two-wire byte handshake
package twbh_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_RATE = 8'h0C;
  localparam int CTRL_FLAG = 7;
  localparam int CTRL_ACKEN = 6;
  localparam int CTRL_START = 5;
  localparam int CTRL_STOP = 4;
  localparam int CTRL_WCOL = 3;
  localparam int CTRL_EN = 2;
  localparam int CTRL_IE = 0;
  localparam logic [7:0] CODE_START = 8'h08;
  localparam logic [7:0] CODE_RSTART = 8'h10;
  localparam logic [7:0] CODE_ADR_ACK = 8'h18;
  localparam logic [7:0] CODE_ADR_NACK = 8'h20;
  localparam logic [7:0] CODE_DAT_ACK = 8'h28;
  localparam logic [7:0] CODE_DAT_NACK = 8'h30;
  localparam logic [7:0] CODE_ARB_LOST = 8'h38;
  localparam logic [7:0] CODE_NO_INFO = 8'hF8;
  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam logic [14:0] HALF_BASE = 15'h0008;
  localparam logic [2:0] LAST_BIT = 3'h7;
  typedef enum logic [3:0] {
    TWBH_IDLE, TWBH_S_LOW, TWBH_S_HIGH, TWBH_S_HOLD,
    TWBH_B_LOW, TWBH_B_HIGH, TWBH_A_LOW, TWBH_A_HIGH,
    TWBH_P_LOW, TWBH_P_HIGH, TWBH_P_DONE
  } twbh_state_t;
endpackage

//--- rtl/twbh_top.sv
// Byte-level two-wire master transmitter with APB register access
`timescale 1ns/10ps
module twbh_top import twbh_pkg::*; (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic GLOBAL_IRQ_EN,
  output logic IRQ_OUT,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE
);

  function automatic logic [14:0] half_len(input logic [7:0] rate,
                                           input logic [1:0] ps);
    half_len = HALF_BASE + (15'(rate) << {ps, 1'b0});
  endfunction

  function automatic logic is_reg(input logic [7:0] a,
                                  input logic [7:0] r);
    is_reg = (a[7:2] == r[7:2]);
  endfunction

  logic scl_m_q, scl_s_q, sda_m_q, sda_s_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic flag_q, ie_q, en_q, acken_q, sta_q, sto_q, wcol_q;
  logic [7:0] data_q, rate_q, code_q, stat_code_q;
  logic [1:0] ps_q;
  twbh_state_t state_q;
  logic [14:0] cnt_q;
  logic [2:0] idx_q;
  logic scl_low_q, sda_low_q, own_q, addr_q, done_q;
  logic scl_oe_q, sda_oe_q, irq_q;
  logic wr_acc, rd_acc, mapped;
  logic ctrl_wr, data_wr, go, run;
  logic [31:0] rd_val;

  // Pins come from outside the clock domain
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      scl_m_q <= SCL_I;
      scl_s_q <= scl_m_q;
      sda_m_q <= SDA_I;
      sda_s_q <= sda_m_q;
    end
  end

  // One wait cycle so read data can come from a flop
  assign mapped = is_reg(PADDR, ADDR_CTRL) | is_reg(PADDR, ADDR_STAT) |
                  is_reg(PADDR, ADDR_DATA) | is_reg(PADDR, ADDR_RATE);
  assign wr_acc = PSEL & PENABLE & pready_q & PWRITE & mapped;
  assign rd_acc = PSEL & PENABLE & !pready_q & !PWRITE;
  assign ctrl_wr = wr_acc & is_reg(PADDR, ADDR_CTRL);
  assign data_wr = wr_acc & is_reg(PADDR, ADDR_DATA);
  // Clear request with enable starts the engine; zero bit does nothing
  // A set flag is cleared by this same write; done_q blocks a set race
  assign go = ctrl_wr & PWDATA[CTRL_FLAG] & PWDATA[CTRL_EN] & !done_q &
              (state_q == TWBH_IDLE);
  // High states count while SCL is still held low or once it is released and seen high
  assign run = scl_s_q | scl_low_q | !((state_q == TWBH_S_HIGH) |
               (state_q == TWBH_B_HIGH) | (state_q == TWBH_A_HIGH) |
               (state_q == TWBH_P_HIGH));

  always_comb begin
    rd_val = 32'h0000_0000;
    if (is_reg(PADDR, ADDR_CTRL)) begin
      rd_val[CTRL_FLAG] = flag_q;
      rd_val[CTRL_ACKEN] = acken_q;
      rd_val[CTRL_START] = sta_q;
      rd_val[CTRL_STOP] = sto_q;
      rd_val[CTRL_WCOL] = wcol_q;
      rd_val[CTRL_EN] = en_q;
      rd_val[CTRL_IE] = ie_q;
    end else if (is_reg(PADDR, ADDR_STAT)) begin
      rd_val[7:0] = {stat_code_q[7:3], 1'b0, ps_q};
    end else if (is_reg(PADDR, ADDR_DATA)) begin
      rd_val[7:0] = data_q;
    end else if (is_reg(PADDR, ADDR_RATE)) begin
      rd_val[7:0] = rate_q;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= PSEL & PENABLE & !pready_q;
      pslverr_q <= PSEL & PENABLE & !pready_q & !mapped;
      if (rd_acc) begin
        prdata_q <= rd_val;
      end
    end
  end

  // Control bits other than the flag and wcol, plus rate and prescaler
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ie_q <= 1'b0;
      en_q <= 1'b0;
      acken_q <= 1'b0;
      sta_q <= 1'b0;
      sto_q <= 1'b0;
      rate_q <= RATE_RESET;
      ps_q <= 2'h0;
    end else begin
      if (ctrl_wr) begin
        ie_q <= PWDATA[CTRL_IE];
        en_q <= PWDATA[CTRL_EN];
        acken_q <= PWDATA[CTRL_ACKEN];
        sta_q <= PWDATA[CTRL_START];
        sto_q <= PWDATA[CTRL_STOP];
      end
      if (wr_acc & is_reg(PADDR, ADDR_RATE)) begin
        rate_q <= PWDATA[7:0];
      end
      if (wr_acc & is_reg(PADDR, ADDR_STAT)) begin
        ps_q <= PWDATA[1:0];
      end
    end
  end

  // Completion flag: hardware set beats a software clear
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flag_q <= 1'b0;
    end else if (done_q) begin
      flag_q <= 1'b1;
    end else if (ctrl_wr & PWDATA[CTRL_FLAG]) begin
      flag_q <= 1'b0;
    end
  end

  // Shared address and data byte; writes only while flag is high
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      data_q <= 8'h00;
      wcol_q <= 1'b0;
    end else if (data_wr) begin
      if (flag_q) begin
        data_q <= PWDATA[7:0];
        wcol_q <= 1'b0;
      end else begin
        wcol_q <= 1'b1;
      end
    end
  end

  // Status lags the flag by one cycle
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      stat_code_q <= CODE_NO_INFO;
    end else begin
      stat_code_q <= flag_q ? code_q : CODE_NO_INFO;
    end
  end

  // Bus engine; idle while the flag is set
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= TWBH_IDLE;
      cnt_q <= 15'h0000;
      idx_q <= LAST_BIT;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      own_q <= 1'b0;
      addr_q <= 1'b0;
      done_q <= 1'b0;
      code_q <= CODE_NO_INFO;
    end else begin
      done_q <= 1'b0;
      if (!en_q && !go) begin
        // Disabling drops the bus mid-byte; no STOP is sent
        state_q <= TWBH_IDLE;
        scl_low_q <= 1'b0;
        sda_low_q <= 1'b0;
        own_q <= 1'b0;
      end else if (state_q == TWBH_IDLE) begin
        if (go) begin
          cnt_q <= half_len(rate_q, ps_q);
          idx_q <= LAST_BIT;
          if (PWDATA[CTRL_START]) begin
            state_q <= own_q ? TWBH_S_LOW : TWBH_S_HIGH;
          end else if (PWDATA[CTRL_STOP]) begin
            state_q <= TWBH_P_LOW;
          end else begin
            state_q <= TWBH_B_LOW;
          end
        end
      end else if (cnt_q != 15'h0000) begin
        if (run) begin
          cnt_q <= cnt_q - 15'h0001;
        end
      end else begin
        cnt_q <= half_len(rate_q, ps_q);
        case (state_q)
          TWBH_S_LOW: begin
            scl_low_q <= 1'b1;
            sda_low_q <= 1'b0;
            state_q <= TWBH_S_HIGH;
          end
          TWBH_S_HIGH: begin
            scl_low_q <= 1'b0;
            // Waits for a free bus before pulling SDA
            if (scl_s_q & sda_s_q) begin
              sda_low_q <= 1'b1;
              state_q <= TWBH_S_HOLD;
            end
          end
          TWBH_S_HOLD: begin
            scl_low_q <= 1'b1;
            code_q <= own_q ? CODE_RSTART : CODE_START;
            done_q <= 1'b1;
            own_q <= 1'b1;
            addr_q <= 1'b1;
            state_q <= TWBH_IDLE;
          end
          TWBH_B_LOW: begin
            scl_low_q <= 1'b1;
            sda_low_q <= !data_q[idx_q];
            state_q <= TWBH_B_HIGH;
          end
          TWBH_B_HIGH: begin
            if (scl_low_q) begin
              scl_low_q <= 1'b0;
            end else if (!sda_low_q & !sda_s_q) begin
              // Another master pulled SDA low: give up the bus
              code_q <= CODE_ARB_LOST;
              done_q <= 1'b1;
              own_q <= 1'b0;
              state_q <= TWBH_IDLE;
            end else begin
              scl_low_q <= 1'b1;
              idx_q <= idx_q - 3'h1;
              state_q <= (idx_q == 3'h0) ? TWBH_A_LOW : TWBH_B_LOW;
            end
          end
          TWBH_A_LOW: begin
            scl_low_q <= 1'b1;
            sda_low_q <= 1'b0;
            state_q <= TWBH_A_HIGH;
          end
          TWBH_A_HIGH: begin
            if (scl_low_q) begin
              scl_low_q <= 1'b0;
            end else begin
              scl_low_q <= 1'b1;
              if (addr_q) begin
                code_q <= sda_s_q ? CODE_ADR_NACK : CODE_ADR_ACK;
              end else begin
                code_q <= sda_s_q ? CODE_DAT_NACK : CODE_DAT_ACK;
              end
              addr_q <= 1'b0;
              done_q <= 1'b1;
              state_q <= TWBH_IDLE;
            end
          end
          TWBH_P_LOW: begin
            scl_low_q <= 1'b1;
            sda_low_q <= 1'b1;
            state_q <= TWBH_P_HIGH;
          end
          TWBH_P_HIGH: begin
            scl_low_q <= 1'b0;
            state_q <= TWBH_P_DONE;
          end
          TWBH_P_DONE: begin
            sda_low_q <= 1'b0;
            own_q <= 1'b0;
            state_q <= TWBH_IDLE;
          end
          default: begin
            state_q <= TWBH_IDLE;
          end
        endcase
      end
    end
  end

  // Pin drivers and interrupt line
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      scl_oe_q <= flag_q | scl_low_q;
      sda_oe_q <= sda_low_q;
      irq_q <= flag_q & ie_q & GLOBAL_IRQ_EN;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign IRQ_OUT = irq_q;
  assign SCL_OE = scl_oe_q;
  assign SDA_OE = sda_oe_q;
  // Open drain: the driven level is always low
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;

endmodule

//--- verif/twbh_monitor.sv
// Port checker for the two-wire byte handshake
`timescale 1ns/10ps
module twbh_monitor (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic GLOBAL_IRQ_EN,
  input wire logic IRQ_OUT,
  input wire logic SCL_O,
  input wire logic SCL_OE,
  input wire logic SDA_OE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  property p_irq_gate; IRQ_OUT |-> $past(GLOBAL_IRQ_EN); endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq without global enable");
  // Both outputs come from the flag sampled at the same edge
  property p_irq_hold; IRQ_OUT |-> SCL_OE; endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("flag set but scl released");
  property p_scl_low; SCL_OE |-> !SCL_O; endproperty
  a_scl_low: assert property (p_scl_low)
    else $error("scl driven high");
  // Flag seen for two cycles: engine must be parked
  property p_idle_sda;
    IRQ_OUT && $past(IRQ_OUT) |-> $past(SDA_OE) == $past(SDA_OE, 2);
  endproperty
  a_idle_sda: assert property (p_idle_sda)
    else $error("sda moved while flag set");
  property p_start_clk; $rose(SDA_OE) && !SCL_OE |-> ##[1:600] SCL_OE;
  endproperty
  a_start_clk: assert property (p_start_clk)
    else $error("no scl low after start");
  property p_stop_free; $fell(SDA_OE) && !SCL_OE |=> !SCL_OE [*8];
  endproperty
  a_stop_free: assert property (p_stop_free)
    else $error("scl stretched after stop");
  property p_ready_wait; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("apb answer late");
  property p_ready_one; PREADY |=> !PREADY; endproperty
  a_ready_one: assert property (p_ready_one)
    else $error("pready longer than one cycle");
  c_start: cover property ($rose(SDA_OE) && !SCL_OE);
  c_stop: cover property ($fell(SDA_OE) && !SCL_OE);
  c_irq: cover property ($rose(IRQ_OUT));
  c_err: cover property (PSLVERR);
endmodule
bind twbh_top twbh_monitor u_mon (.MCLK, .ARST_N, .PSEL, .PENABLE, .PREADY,
  .PSLVERR, .GLOBAL_IRQ_EN, .IRQ_OUT, .SCL_O, .SCL_OE, .SDA_OE);

//--- verif/twbh_slave_model.sv
// Behavioural slave receiver on the two-wire bus
`timescale 1ns/10ps
module twbh_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  input wire logic slow,
  output logic sda_oe,
  output logic scl_oe,
  output logic [7:0] rx_byte,
  output logic rx_stb
);
  int cnt = 0;
  initial begin
    sda_oe = 1'b0;
    scl_oe = 1'b0;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
  end
  // Start seen; its own scl fall brings the count to zero
  always @(negedge sda) if (scl) cnt = -1;
  always @(posedge scl) if (cnt < 8) rx_byte = {rx_byte[6:0], sda};
  always @(negedge scl) begin
    cnt = cnt + 1;
    sda_oe = (cnt == 8) && !nack;
    rx_stb = (cnt == 8);
    if (cnt == 9) begin
      cnt = 0;
      // Slow answer stretches the low phase
      if (slow) begin
        scl_oe = 1'b1;
        #300 scl_oe = 1'b0;
      end
    end
  end
endmodule

//--- verif/tb_twbh_top.sv
// Self-checking bench for the two-wire byte handshake
`timescale 1ns/10ps
module tb_twbh_top import twbh_pkg::*; ;
  logic MCLK = 1'b0;
  logic ARST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic GLOBAL_IRQ_EN = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA, r, m, x;
  logic PREADY, PSLVERR, IRQ_OUT, SCL_OE, SDA_OE, e_b;
  logic s_scl, s_sda, rx_stb, scl_w, sda_w;
  logic nack = 1'b0;
  logic slow = 1'b0;
  logic [7:0] rx_byte;
  logic [31:0] exp_q[$], msk_q[$];
  logic [7:0] byte_q[$];
  int n_errors = 0;
  int check_count = 0;
  // Open-drain wires with pull-ups
  assign scl_w = !(SCL_OE || s_scl);
  assign sda_w = !(SDA_OE || s_sda);
  always #5 MCLK = ~MCLK;
  twbh_top uut (.MCLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .GLOBAL_IRQ_EN, .IRQ_OUT, .SCL_I(scl_w),
    .SCL_O(), .SCL_OE, .SDA_I(sda_w), .SDA_O(), .SDA_OE);
  twbh_slave_model u_slave (.scl(scl_w), .sda(sda_w), .nack, .slow,
    .sda_oe(s_sda), .scl_oe(s_scl), .rx_byte, .rx_stb);
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, d, mk,
    output logic [31:0] q, output logic e);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h00_0000, d};
    if (!w) begin
      exp_q.push_back({24'h00_0000, d});
      msk_q.push_back({24'h00_0000, mk});
    end
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask
  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, d, 8'h00, r, e_b);
  endtask
  task automatic rd(input logic [7:0] a, xv, mk);
    apb(1'b0, a, xv, mk, r, e_b);
  endtask
  task automatic poll();
    r = 32'h0000_0000;
    for (int i = 0; i < 300 && r[CTRL_FLAG] !== 1'b1; i++) begin
      rd(ADDR_CTRL, 8'h00, 8'h00);
    end
    chk("flag", r & 32'h0000_0080, 32'h0000_0080);
    chk("scl_hold", {31'h0000_0000, SCL_OE}, 32'h0000_0001);
    chk("irq", {31'h0000_0000, IRQ_OUT},
      {31'h0000_0000, GLOBAL_IRQ_EN});
  endtask
  task automatic xfer(input logic [7:0] b, input logic nk,
    input logic [7:0] code);
    wr(ADDR_DATA, b);
    wr(ADDR_CTRL, 8'h05);
    rd(ADDR_CTRL, 8'h80, 8'h88);
    nack <= nk;
    byte_q.push_back(b);
    wr(ADDR_CTRL, 8'h85);
    poll();
    rd(ADDR_STAT, code, 8'hF8);
  endtask
  task automatic start_op(input logic [7:0] code);
    wr(ADDR_CTRL, 8'hA5);
    poll();
    rd(ADDR_STAT, code, 8'hF8);
  endtask
  task automatic stop_op();
    wr(ADDR_CTRL, 8'h95);
    repeat (300) @(posedge MCLK);
    rd(ADDR_CTRL, 8'h00, 8'h80);
    rd(ADDR_STAT, CODE_NO_INFO, 8'hF8);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge MCLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) begin
      x = exp_q.pop_front();
      m = msk_q.pop_front();
      if (m != 32'h0000_0000) chk("prdata", PRDATA & m, x & m);
    end
  end
  always @(posedge rx_stb) begin
    chk("byte", {24'h00_0000, rx_byte},
      {24'h00_0000, byte_q.pop_front()});
  end
  initial begin
    #300000;
    n_errors++;
    end_sim();
  end
  initial begin
    x = $urandom(35);
    repeat (12) @(posedge MCLK);
    ARST_N <= 1'b1;
    @(posedge MCLK);
    rd(ADDR_STAT, CODE_NO_INFO, 8'hF8);
    wr(ADDR_DATA, 8'h5A);
    rd(ADDR_CTRL, 8'h08, 8'h08);
    wr(ADDR_CTRL, 8'h25);
    rd(ADDR_STAT, CODE_NO_INFO, 8'hF8);
    apb(1'b0, 8'h10, 8'h00, 8'h00, r, e_b);
    chk("slverr", {31'h0000_0000, e_b}, 32'h0000_0001);
    $display("test registers done");
    GLOBAL_IRQ_EN <= 1'b1;
    start_op(CODE_START);
    r = $urandom;
    xfer({r[6:0], 1'b0}, 1'b0, CODE_ADR_ACK);
    for (int i = 0; i < 3; i++) begin
      r = $urandom;
      slow <= r[8];
      xfer(r[7:0], i == 2,
        (i == 2) ? CODE_DAT_NACK : CODE_DAT_ACK);
    end
    // Repeated start while the bus is still owned
    start_op(CODE_RSTART);
    r = $urandom;
    xfer({r[6:0], 1'b0}, 1'b0, CODE_ADR_ACK);
    stop_op();
    $display("test write frame done");
    GLOBAL_IRQ_EN <= 1'b0;
    start_op(CODE_START);
    r = $urandom;
    xfer({r[6:0], 1'b0}, 1'b1, CODE_ADR_NACK);
    stop_op();
    chk("rx_left", byte_q.size(), 32'h0000_0000);
    $display("test address nack done");
    end_sim();
  end
endmodule
